// ===== rtl/sdc_pkg.sv
// Purpose: Shared constants for the segment descriptor decode/check block
// Assumes: 32-bit AHB-Lite register bus, word aligned registers
// Notes:   Offsets are byte addresses

`default_nettype none

package sdc_pkg;
  localparam logic [4:0] SDC_OFF_DESC_LO = 5'h00;
  localparam logic [4:0] SDC_OFF_DESC_HI = 5'h04;
  localparam logic [4:0] SDC_OFF_OFFSET  = 5'h08;
  localparam logic [4:0] SDC_OFF_CMD     = 5'h0C;
  localparam logic [4:0] SDC_OFF_STATUS  = 5'h10;
  localparam logic [4:0] SDC_OFF_BASE    = 5'h14;
  localparam logic [4:0] SDC_OFF_LIMIT   = 5'h18;

  // Access rights byte sits in bits 15:8 of the upper word
  localparam int SDC_AR_LSB      = 8;
  localparam int SDC_BIT_ACCESS  = 8;
  localparam int SDC_BIT_PRESENT = 15;
  localparam int SDC_DPL_LSB     = 13;
  localparam int SDC_BIT_S       = 12;
  localparam int SDC_BIT_EXEC    = 11;
  localparam int SDC_BIT_DIRCONF = 10;
  localparam int SDC_BIT_WRRD    = 9;
  localparam int SDC_BIT_BIG     = 22;
  localparam int SDC_BIT_GRAN    = 23;
  localparam int SDC_PAGE_SHIFT  = 12;

  // Command register fields
  localparam int SDC_CMD_CPL_LSB = 4;

  // Status register fields
  localparam int SDC_ST_DONE  = 0;
  localparam int SDC_ST_FAULT = 1;
  localparam int SDC_ST_NP    = 2;
  localparam int SDC_ST_VEC   = 8;
  localparam int SDC_ST_WIDE  = 16;
  localparam int SDC_ST_OP32  = 17;
  localparam int SDC_ST_DPL   = 18;
  localparam int SDC_ST_CODE  = 20;
  localparam int SDC_ST_SYS   = 21;
  localparam int SDC_ST_LEG   = 22;

  localparam logic [7:0]  SDC_VEC_NONE    = 8'h00;
  localparam logic [7:0]  SDC_VEC_NP      = 8'h0B;
  localparam logic [7:0]  SDC_VEC_PROT    = 8'h0D;
  localparam logic [31:0] SDC_TOP_WIDE    = 32'hFFFFFFFF;
  localparam logic [31:0] SDC_TOP_NARROW  = 32'h0000FFFF;
  localparam logic [31:0] SDC_RESET_WORD  = 32'h00000000;

  typedef enum logic [2:0] {
    SDC_K_FETCH,
    SDC_K_READ,
    SDC_K_WRITE,
    SDC_K_LOAD,
    SDC_K_TEST
  } sdc_kind_e;
endpackage : sdc_pkg

`default_nettype wire

// ===== rtl/sdc_desc_if.sv
// Purpose: Carries descriptor words and their decoded fields
// Assumes: Decode is purely combinational
// Notes:   Owner drives words, decoder drives fields
`timescale 1ns/1ps
`default_nettype none

interface sdc_desc_if;
  logic [31:0] lo;
  logic [31:0] hi;
  logic [31:0] base;
  logic [31:0] lim_eff;
  logic        present;
  logic [1:0]  descriptor_privilege_level;
  logic        code_data;
  logic        exec;
  logic        dir_conf;
  logic        wr_rd;
  logic        big;
  logic        legacy;
  modport owner (output lo, hi, input base, lim_eff, present, descriptor_privilege_level,
                 code_data, exec, dir_conf, wr_rd, big, legacy);
  modport dec   (input lo, hi, output base, lim_eff, present, descriptor_privilege_level,
                 code_data, exec, dir_conf, wr_rd, big, legacy);
endinterface : sdc_desc_if

`default_nettype wire

// ===== rtl/sdc_decode.sv
// Purpose: Field extraction from an 8-byte segment descriptor
// Assumes: lo is the word at +0, hi the word at +4
// Notes:   Combinational only
`timescale 1ns/1ps
`default_nettype none

module sdc_decode (
  sdc_desc_if.dec d
);
  logic [19:0] lim_raw;
  logic        gran;

  always_comb begin
    d.present   = d.hi[sdc_pkg::SDC_BIT_PRESENT];
    d.descriptor_privilege_level       = d.hi[sdc_pkg::SDC_DPL_LSB +: 2];
    d.code_data = d.hi[sdc_pkg::SDC_BIT_S];
    d.exec      = d.hi[sdc_pkg::SDC_BIT_EXEC];
    d.dir_conf  = d.hi[sdc_pkg::SDC_BIT_DIRCONF];
    d.wr_rd     = d.hi[sdc_pkg::SDC_BIT_WRRD];
    d.big       = d.hi[sdc_pkg::SDC_BIT_BIG];
    gran        = d.hi[sdc_pkg::SDC_BIT_GRAN];
    // Old system format: upper half word all zero
    d.legacy    = !d.hi[sdc_pkg::SDC_BIT_S] && (d.hi[31:16] == 16'h0000);
    lim_raw     = {d.hi[19:16], d.lo[15:0]};
    if (d.legacy) begin
      d.base    = {8'h00, d.hi[7:0], d.lo[31:16]};
      d.lim_eff = {16'h0000, d.lo[15:0]};
    end else begin
      d.base    = {d.hi[31:24], d.hi[7:0], d.lo[31:16]};
      // Same scaling whether paging is on or off
      if (gran) begin
        d.lim_eff = {lim_raw, 12'hFFF};
      end else begin
        d.lim_eff = {12'h000, lim_raw};
      end
    end
  end
endmodule : sdc_decode

`default_nettype wire

// ===== rtl/sdc_top.sv
// Purpose: Segment descriptor decode and access check, AHB-Lite slave
// Assumes: Single word transfers; software loads descriptor then command
// Notes:   Writing CMD runs one check; result visible next cycle
// Function
// - Build 32-bit base and 20-bit limit from split descriptor fields.
// - Granularity 0 means byte limit; 1 means 4 KB page limit.
// - Granularity handled the same with or without paging.
// - Present bit 7 clear: segment unmapped, base and limit unused.
// - Access to a non-present segment raises not-present, vector 11.
// - Bits 6-5 give descriptor privilege level for privilege checks.
// - Bit 4 set: code or data; clear: system or gate.
// - Bit 3 selects code (1) or data (0).
// - Code reads allowed only when readable bit is set.
// - Writes through a code segment are always refused.
// - Conforming code executes only when current level >= descriptor level.
// - Accessed bit set on segment load or selector test.
// - Code operand-size flag selects 32-bit or 16-bit defaults.
// - Data bit 2: expand up needs offset <= limit, down needs offset > limit.
// - Data writes refused unless writable bit set.
// - Stack big flag picks wide pointer and top, else narrow pointer.
// - Upper 16 bits zero: old system format, 24-bit base, 16-bit limit.
`timescale 1ns/1ps
`default_nettype none

module sdc_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             access_grant,
  output logic             access_fault
);
  sdc_desc_if dif ();

  logic [31:0] desc_lo_reg;
  logic [31:0] desc_hi_reg;
  logic [31:0] offset_reg;
  logic [31:0] status_reg;
  logic [31:0] base_reg;
  logic [31:0] limit_reg;
  logic [31:0] hrdata_reg;
  logic [4:0]  addr_reg;
  logic        wr_pend_reg;
  logic        rd_wait_reg;
  logic        grant_reg;
  logic        fault_reg;

  logic             cmd_wr;
  sdc_pkg::sdc_kind_e kind;
  logic [1:0]       current_privilege_level;
  logic             is_mem;
  logic             perm_ok;
  logic             lim_ok;
  logic             np;
  logic             fault_next;
  logic [31:0]      top;
  logic [7:0]       vec_next;
  logic             mark_acc;
  logic [31:0]      rd_mux;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
    hit = (a[4:2] == o[4:2]);
  endfunction : hit

  assign dif.lo = desc_lo_reg;
  assign dif.hi = desc_hi_reg;

  sdc_decode u_dec (
    .d (dif)
  );

  // Bus address phase
  logic accept;
  assign accept    = hsel && hready && htrans[1];
  assign hreadyout = !rd_wait_reg;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  // Reads take one wait state so read data comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg    <= 5'h00;
      wr_pend_reg <= 1'b0;
      rd_wait_reg <= 1'b0;
    end else begin
      wr_pend_reg <= accept && hwrite;
      rd_wait_reg <= accept && !hwrite;
      if (accept) begin
        addr_reg <= haddr[4:0];
      end
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    if (hit(addr_reg, sdc_pkg::SDC_OFF_DESC_LO)) rd_mux = desc_lo_reg;
    if (hit(addr_reg, sdc_pkg::SDC_OFF_DESC_HI)) rd_mux = desc_hi_reg;
    if (hit(addr_reg, sdc_pkg::SDC_OFF_OFFSET))  rd_mux = offset_reg;
    if (hit(addr_reg, sdc_pkg::SDC_OFF_STATUS))  rd_mux = status_reg;
    if (hit(addr_reg, sdc_pkg::SDC_OFF_BASE))    rd_mux = base_reg;
    if (hit(addr_reg, sdc_pkg::SDC_OFF_LIMIT))   rd_mux = limit_reg;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= sdc_pkg::SDC_RESET_WORD;
    end else if (rd_wait_reg) begin
      hrdata_reg <= rd_mux;
    end
  end

  assign cmd_wr = wr_pend_reg && hit(addr_reg, sdc_pkg::SDC_OFF_CMD);
  assign kind   = sdc_pkg::sdc_kind_e'(hwdata[2:0]);
  assign current_privilege_level    = hwdata[sdc_pkg::SDC_CMD_CPL_LSB +: 2];
  assign is_mem = (kind == sdc_pkg::SDC_K_FETCH) ||
                  (kind == sdc_pkg::SDC_K_READ) ||
                  (kind == sdc_pkg::SDC_K_WRITE);

  // Permission and limit check
  always_comb begin
    perm_ok = 1'b0;
    top     = dif.big ? sdc_pkg::SDC_TOP_WIDE
                      : sdc_pkg::SDC_TOP_NARROW;
    lim_ok  = offset_reg <= dif.lim_eff;
    if (!dif.code_data) begin
      perm_ok = 1'b0;
    end else if (dif.exec) begin
      case (kind)
        sdc_pkg::SDC_K_FETCH: perm_ok = !dif.dir_conf ||
                                        (current_privilege_level >= dif.descriptor_privilege_level);
        sdc_pkg::SDC_K_READ:  perm_ok = dif.wr_rd;
        sdc_pkg::SDC_K_WRITE: perm_ok = 1'b0;
        default:              perm_ok = 1'b0;
      endcase
    end else begin
      case (kind)
        sdc_pkg::SDC_K_READ:  perm_ok = 1'b1;
        sdc_pkg::SDC_K_WRITE: perm_ok = dif.wr_rd;
        default:              perm_ok = 1'b0;
      endcase
      if (dif.dir_conf) begin
        lim_ok = (offset_reg > dif.lim_eff) &&
                 (offset_reg <= top);
      end
    end
  end

  // Not present wins over every other check
  assign np         = is_mem && !dif.present;
  assign fault_next = is_mem && dif.present && !(perm_ok && lim_ok);
  assign vec_next   = np ? sdc_pkg::SDC_VEC_NP :
                      fault_next ? sdc_pkg::SDC_VEC_PROT :
                      sdc_pkg::SDC_VEC_NONE;
  assign mark_acc   = cmd_wr && dif.code_data &&
                      ((kind == sdc_pkg::SDC_K_LOAD) ||
                       (kind == sdc_pkg::SDC_K_TEST));

  // Descriptor and offset registers; hardware set of accessed bit wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      desc_lo_reg <= sdc_pkg::SDC_RESET_WORD;
      desc_hi_reg <= sdc_pkg::SDC_RESET_WORD;
      offset_reg  <= sdc_pkg::SDC_RESET_WORD;
    end else begin
      if (wr_pend_reg && hit(addr_reg, sdc_pkg::SDC_OFF_DESC_LO)) begin
        desc_lo_reg <= hwdata;
      end
      if (wr_pend_reg && hit(addr_reg, sdc_pkg::SDC_OFF_DESC_HI)) begin
        desc_hi_reg <= hwdata;
      end
      if (mark_acc) begin
        desc_hi_reg[sdc_pkg::SDC_BIT_ACCESS] <= 1'b1;
      end
      if (wr_pend_reg && hit(addr_reg, sdc_pkg::SDC_OFF_OFFSET)) begin
        offset_reg <= hwdata;
      end
    end
  end

  // Check result; base and limit hidden when not present
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= sdc_pkg::SDC_RESET_WORD;
      base_reg   <= sdc_pkg::SDC_RESET_WORD;
      limit_reg  <= sdc_pkg::SDC_RESET_WORD;
      grant_reg  <= 1'b0;
      fault_reg  <= 1'b0;
    end else if (cmd_wr) begin
      status_reg                               <= 32'h00000000;
      status_reg[sdc_pkg::SDC_ST_DONE]         <= 1'b1;
      status_reg[sdc_pkg::SDC_ST_FAULT]        <= fault_next;
      status_reg[sdc_pkg::SDC_ST_NP]           <= np;
      status_reg[sdc_pkg::SDC_ST_VEC +: 8]     <= vec_next;
      status_reg[sdc_pkg::SDC_ST_WIDE]         <= dif.code_data &&
                                                  !dif.exec && dif.big;
      status_reg[sdc_pkg::SDC_ST_OP32]         <= dif.code_data &&
                                                  dif.exec && dif.big;
      status_reg[sdc_pkg::SDC_ST_DPL +: 2]     <= dif.descriptor_privilege_level;
      status_reg[sdc_pkg::SDC_ST_CODE]         <= dif.code_data &&
                                                  dif.exec;
      status_reg[sdc_pkg::SDC_ST_SYS]          <= !dif.code_data;
      status_reg[sdc_pkg::SDC_ST_LEG]          <= dif.legacy;
      base_reg   <= dif.present ? dif.base : 32'h00000000;
      limit_reg  <= dif.present ? dif.lim_eff : 32'h00000000;
      grant_reg  <= is_mem && !np && !fault_next;
      fault_reg  <= np || fault_next;
    end else begin
      grant_reg <= 1'b0;
      fault_reg <= 1'b0;
    end
  end

  assign access_grant = grant_reg;
  assign access_fault = fault_reg;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_np_vector: assert property (
    cmd_wr && is_mem && !dif.present |=>
      access_fault && status_reg[sdc_pkg::SDC_ST_VEC +: 8] == 8'h0B)
    else $error("not present access without vector 11");

  a_code_write: assert property (
    cmd_wr && dif.code_data && dif.exec &&
    kind == sdc_pkg::SDC_K_WRITE |=> !access_grant)
    else $error("write through code segment granted");

  a_ro_data: assert property (
    cmd_wr && dif.code_data && !dif.exec && !dif.wr_rd &&
    kind == sdc_pkg::SDC_K_WRITE |=> access_fault)
    else $error("write to read-only data segment allowed");

  a_exec_only: assert property (
    cmd_wr && dif.present && dif.code_data && dif.exec &&
    !dif.wr_rd && kind == sdc_pkg::SDC_K_READ |=> access_fault)
    else $error("read of execute-only code allowed");

  a_conform_lvl: assert property (
    cmd_wr && dif.present && dif.code_data && dif.exec &&
    dif.dir_conf && kind == sdc_pkg::SDC_K_FETCH &&
    current_privilege_level < dif.descriptor_privilege_level |=> access_fault && !access_grant)
    else $error("conforming fetch from lower level allowed");

  a_up_limit: assert property (
    cmd_wr && is_mem && dif.present && dif.code_data && !dif.exec &&
    !dif.dir_conf && offset_reg > dif.lim_eff |=> access_fault)
    else $error("expand up offset beyond limit allowed");

  a_down_limit: assert property (
    cmd_wr && dif.present && dif.code_data && !dif.exec &&
    dif.dir_conf && kind == sdc_pkg::SDC_K_READ &&
    offset_reg <= dif.lim_eff |=> access_fault)
    else $error("expand down offset at or below limit allowed");

  a_page_limit: assert property (
    cmd_wr && dif.present && !dif.legacy &&
    desc_hi_reg[sdc_pkg::SDC_BIT_GRAN] |=>
      limit_reg[11:0] == 12'hFFF &&
      limit_reg[31:12] == {$past(desc_hi_reg[19:16]),
                           $past(desc_lo_reg[15:0])})
    else $error("page granular limit wrong");

  a_legacy_base: assert property (
    cmd_wr && dif.present && dif.legacy |=>
      base_reg[31:24] == 8'h00 && limit_reg[31:16] == 16'h0000)
    else $error("old format descriptor kept wide fields");

  a_acc_set: assert property (
    mark_acc |=> desc_hi_reg[sdc_pkg::SDC_BIT_ACCESS] ##1
      (desc_hi_reg[sdc_pkg::SDC_BIT_ACCESS] || $past(wr_pend_reg)))
    else $error("accessed bit not set on load");

  a_read_wait: assert property (
    accept && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  a_np_hidden: assert property (
    cmd_wr && !dif.present |=> base_reg == 32'h00000000 &&
      limit_reg == 32'h00000000)
    else $error("base or limit shown for absent segment");

  a_stack_width: assert property (
    cmd_wr && dif.code_data && !dif.exec |=>
      status_reg[sdc_pkg::SDC_ST_WIDE] ==
        $past(desc_hi_reg[sdc_pkg::SDC_BIT_BIG]))
    else $error("stack pointer width wrong");

  a_one_result: assert property (
    !(access_grant && access_fault))
    else $error("grant and fault together");

  c_grant:  cover property (cmd_wr ##1 access_grant);
  c_np:     cover property (cmd_wr && np);
  c_down:   cover property (cmd_wr && dif.dir_conf && !dif.exec);
  c_legacy: cover property (cmd_wr && dif.legacy);
  c_page:   cover property (cmd_wr && desc_hi_reg[sdc_pkg::SDC_BIT_GRAN]);
endmodule : sdc_top

`default_nettype wire

// ===== dv/tb_sdc_top.sv
// Purpose: Self-checking bench for the descriptor decode and check block
// Assumes: Word transfers only; hready loops back from hreadyout
// Notes:   Each scenario after t_reset loads a descriptor, issues a command, reads status
`timescale 1ns/1ps
`default_nettype none

module tb_sdc_top;
  localparam logic [2:0] KF = sdc_pkg::SDC_K_FETCH;
  localparam logic [2:0] KR = sdc_pkg::SDC_K_READ;
  localparam logic [2:0] KW = sdc_pkg::SDC_K_WRITE;
  localparam logic [2:0] KL = sdc_pkg::SDC_K_LOAD;
  localparam logic [2:0] KT = sdc_pkg::SDC_K_TEST;
  // Generous: the whole run needs well under a thousand cycles
  localparam int         TIMEOUT = 20000;

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        access_grant;
  logic        access_fault;
  logic [31:0] rd;
  logic [31:0] st;
  int          err_total = 0;
  int          checked = 0;
  int          cycles = 0;

  sdc_top sdc_top_inst (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .hsel         (hsel),
    .haddr        (haddr),
    .htrans       (htrans),
    .hwrite       (hwrite),
    .hsize        (hsize),
    .hwdata       (hwdata),
    .hready       (hreadyout),
    .hrdata       (hrdata),
    .hreadyout    (hreadyout),
    .hresp        (hresp),
    .access_grant (access_grant),
    .access_fault (access_fault)
  );

  always #25 hclk = ~hclk;

  task automatic print_verdict;
    if (err_total == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT) begin
      err_total++;
      print_verdict;
    end
  end

  task automatic cmp32(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp32

  task automatic cmp1(string what, logic exp, logic got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp1

  // Called just after a rising edge; returns just after the data phase
  task automatic bus(logic wr, logic [4:0] off, logic [31:0] wd,
                     output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {27'h0, off};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus

  function automatic logic [63:0] desc(logic [31:0] b, logic [19:0] l,
                                       logic g, logic d, logic [7:0] ar);
    return {b[31:24], g, d, 1'b0, 1'b0, l[19:16], ar, b[23:16], b[15:0],
            l[15:0]};
  endfunction : desc

  // Load descriptor and offset, run one command, judge pulses and vector
  task automatic go(logic [63:0] d, logic [31:0] off, logic [2:0] kind,
                    logic [1:0] current_privilege_level, logic eg, logic ef);
    logic [7:0] v;
    v = !ef ? sdc_pkg::SDC_VEC_NONE :
        (d[47] ? sdc_pkg::SDC_VEC_PROT : sdc_pkg::SDC_VEC_NP);
    bus(1'b1, sdc_pkg::SDC_OFF_DESC_LO, d[31:0], rd);
    bus(1'b1, sdc_pkg::SDC_OFF_DESC_HI, d[63:32], rd);
    bus(1'b1, sdc_pkg::SDC_OFF_OFFSET, off, rd);
    bus(1'b1, sdc_pkg::SDC_OFF_CMD, {26'h0, current_privilege_level, 1'b0, kind}, rd);
    #1;
    cmp1("grant", eg, access_grant);
    cmp1("fault", ef, access_fault);
    @(posedge hclk);
    bus(1'b0, sdc_pkg::SDC_OFF_STATUS, 32'h00000000, st);
    cmp1("done", 1'b1, st[0]);
    cmp32("vector", {24'h000000, v}, {24'h000000, st[15:8]});
    cmp1("fault flag", ef && d[47], st[1]);
    cmp1("np flag", ef && !d[47], st[2]);
  endtask : go

  task automatic rd_cmp(logic [4:0] off, string what, logic [31:0] exp);
    bus(1'b0, off, 32'h00000000, rd);
    cmp32(what, exp, rd);
  endtask : rd_cmp

  task automatic t_reset;
    rd_cmp(sdc_pkg::SDC_OFF_STATUS, "status", sdc_pkg::SDC_RESET_WORD);
    bus(1'b1, sdc_pkg::SDC_OFF_BASE, 32'hFFFFFFFF, rd);
    rd_cmp(sdc_pkg::SDC_OFF_BASE, "base ro", sdc_pkg::SDC_RESET_WORD);
    bus(1'b1, 5'h1C, 32'hFFFFFFFF, rd);
    rd_cmp(5'h1C, "unmapped", 32'h00000000);
    cmp1("hresp", 1'b0, hresp);
  endtask : t_reset

  task automatic t_limits;
    logic [63:0] d;
    d = desc(32'h12345000, 20'hABCDE, 1'b0, 1'b0, 8'h92);
    go(d, 32'h000ABCDE, KR, 2'h0, 1'b1, 1'b0);
    rd_cmp(sdc_pkg::SDC_OFF_BASE, "base", 32'h12345000);
    rd_cmp(sdc_pkg::SDC_OFF_LIMIT, "limit", 32'h000ABCDE);
    go(d, 32'h000ABCDF, KR, 2'h0, 1'b0, 1'b1);
    d = desc(32'h12345000, 20'hABCDE, 1'b1, 1'b0, 8'h92);
    go(d, 32'hABCDEFFF, KR, 2'h0, 1'b1, 1'b0);
    rd_cmp(sdc_pkg::SDC_OFF_LIMIT, "page limit", 32'hABCDEFFF);
    go(d, 32'hABCDF000, KR, 2'h0, 1'b0, 1'b1);
  endtask : t_limits

  task automatic t_absent;
    logic [63:0] d;
    d = desc(32'h00400000, 20'h00FFF, 1'b0, 1'b0, 8'h12);
    go(d, 32'h00000010, KR, 2'h0, 1'b0, 1'b1);
    cmp1("np flag", 1'b1, st[2]);
    rd_cmp(sdc_pkg::SDC_OFF_BASE, "np base", 32'h00000000);
    rd_cmp(sdc_pkg::SDC_OFF_LIMIT, "np limit", 32'h00000000);
  endtask : t_absent

  task automatic t_fields;
    logic [63:0] d;
    for (int i = 0; i < 4; i++) begin
      d = desc(32'h0, 20'hFFFFF, 1'b0, i[0], {1'b1, i[1:0], 5'h1A});
      go(d, 32'h00000000, KL, 2'h0, 1'b0, 1'b0);
      cmp32("dpl", {30'h0, i[1:0]}, {30'h0, st[19:18]});
      cmp1("code", 1'b1, st[20]);
      cmp1("op32", i[0], st[17]);
    end
    d = desc(32'h0, 20'hFFFFF, 1'b0, 1'b1, 8'h92);
    go(d, 32'h00000000, KL, 2'h0, 1'b0, 1'b0);
    cmp1("wide sp", 1'b1, st[16]);
    cmp1("data", 1'b0, st[20]);
    cmp1("system", 1'b0, st[21]);
  endtask : t_fields

  task automatic t_code;
    logic [63:0] d;
    d = desc(32'h0, 20'hFFFFF, 1'b0, 1'b0, 8'h98);
    go(d, 32'h00000010, KF, 2'h0, 1'b1, 1'b0);
    go(d, 32'h00000010, KR, 2'h0, 1'b0, 1'b1);
    d = desc(32'h0, 20'hFFFFF, 1'b0, 1'b0, 8'h9A);
    go(d, 32'h00000010, KR, 2'h0, 1'b1, 1'b0);
    go(d, 32'h00000010, KW, 2'h0, 1'b0, 1'b1);
    d = desc(32'h0, 20'hFFFFF, 1'b0, 1'b0, 8'hDE);
    go(d, 32'h00000010, KF, 2'h1, 1'b0, 1'b1);
    go(d, 32'h00000010, KF, 2'h2, 1'b1, 1'b0);
    go(d, 32'h00000010, KF, 2'h3, 1'b1, 1'b0);
    go(d, 32'h00000010, KW, 2'h3, 1'b0, 1'b1);
  endtask : t_code

  task automatic t_data;
    logic [63:0] d;
    d = desc(32'h0, 20'hFFFFF, 1'b0, 1'b0, 8'h90);
    go(d, 32'h00000020, KW, 2'h0, 1'b0, 1'b1);
    go(d, 32'h00000020, KR, 2'h0, 1'b1, 1'b0);
    d = desc(32'h0, 20'hFFFFF, 1'b0, 1'b0, 8'h92);
    go(d, 32'h00000020, KW, 2'h0, 1'b1, 1'b0);
    d = desc(32'h0, 20'h00FFF, 1'b0, 1'b0, 8'h96);
    go(d, 32'h00000FFF, KW, 2'h0, 1'b0, 1'b1);
    go(d, 32'h00001000, KW, 2'h0, 1'b1, 1'b0);
    go(d, 32'h0000FFFF, KW, 2'h0, 1'b1, 1'b0);
    go(d, 32'h00010000, KW, 2'h0, 1'b0, 1'b1);
    d = desc(32'h0, 20'h00FFF, 1'b0, 1'b1, 8'h96);
    go(d, 32'h00010000, KW, 2'h0, 1'b1, 1'b0);
    go(d, 32'hFFFFFFFF, KW, 2'h0, 1'b1, 1'b0);
  endtask : t_data

  task automatic t_access;
    logic [63:0] d;
    d = desc(32'h0, 20'h00010, 1'b0, 1'b0, 8'h92);
    go(d, 32'h00000000, 3'h5, 2'h0, 1'b0, 1'b0);
    rd_cmp(sdc_pkg::SDC_OFF_DESC_HI, "acc none", d[63:32]);
    go(d, 32'h00000000, KL, 2'h0, 1'b0, 1'b0);
    rd_cmp(sdc_pkg::SDC_OFF_DESC_HI, "acc load", d[63:32] | 32'h100);
    go(d, 32'h00000000, KT, 2'h0, 1'b0, 1'b0);
    rd_cmp(sdc_pkg::SDC_OFF_DESC_HI, "acc test", d[63:32] | 32'h100);
  endtask : t_access

  task automatic t_legacy;
    logic [63:0] d;
    d = {32'h00008256, 32'h12340FFF};
    go(d, 32'h00000000, KL, 2'h0, 1'b0, 1'b0);
    cmp1("old fmt", 1'b1, st[22]);
    cmp1("system", 1'b1, st[21]);
    rd_cmp(sdc_pkg::SDC_OFF_BASE, "old base", 32'h00561234);
    rd_cmp(sdc_pkg::SDC_OFF_LIMIT, "old limit", 32'h00000FFF);
    d = {32'h00018256, 32'h12340FFF};
    go(d, 32'h00000000, KF, 2'h0, 1'b0, 1'b1);
    cmp1("native fmt", 1'b0, st[22]);
  endtask : t_legacy

  initial begin
    hclk    = 1'b0;
    hresetn = 1'b0;
    hsel    = 1'b0;
    haddr   = 32'h00000000;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hsize   = 3'h2;
    hwdata  = 32'h00000000;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_limits;
    t_absent;
    t_fields;
    t_code;
    t_data;
    t_access;
    t_legacy;
    print_verdict;
  end
endmodule : tb_sdc_top

`default_nettype wire
